// ==== src/lhi_device.sv ====
// lhi_device.sv: lcd controller end of the host port
// assumes: pins come from another domain and are synchronised here;
// the straps are steady while the host is idle
// Summary of operation
// - data select high stores RAM, low decodes command
// - 6800: read-write high reads, low writes
// - 6800: enable high latches when chip selected
// - host issues dummy read before first data read
// - 8080: read strobe low latches read data
// - 8080: read gives RAM or status by select
// - 8080: write strobe high latches, select steers
// - 8080 host also does one dummy read
// - serial: shift bit on rising clock, msb first
// - serial: eighth clock samples select, writes byte
// - serial: data on bit 7, clock on 6
// - interface strap high parallel, low serial
// - bus style strap picks 6800 or 8080
// - serial port is write only
// - reset clears the serial shift register
`timescale 1ns/100ps
`include "lhi_defines.svh"
module lhi_device import lhi_pkg::*; #(
   parameter int RAM_DEPTH = `LHI_RAM_DEPTH,
   parameter int FIFO_DEPTH = `LHI_FIFO_DEPTH
) (
   input wire logic ref_clk_i, // 20 mhz system clock
   input wire logic rst_i, // async reset, active high
   lhi_if.dev bus, // host pins
   input wire logic parallel_strap_i, // high parallel, low serial
   input wire logic bus_style_strap_i, // high 6800, low 8080
   input wire logic [7:0] status_i, // status byte to read back
   output logic [7:0] cmd_o, // decoded command byte
   output logic cmd_valid_o, // command byte valid
   input wire logic cmd_ready_i, // consumer takes command
   output logic [`LHI_RAM_AW-1:0] ram_addr_o // display ram pointer
);
   logic [7:0] d_s1, d_s2;
   logic [4:0] c_s1, c_s2;
   logic [2:0] st_s1, st_s2;
   logic sel, dc, rw_wr, e_rd, sck, sda, sck_d, strobe_d;
   logic strobe, strobe_rise, sck_rise;
   lhi_mode_t mode;
   logic [7:0] shreg;
   logic [3:0] bitcnt;
   logic wr_ev, rd_ev;
   logic [7:0] wr_byte;
   logic wr_dc;
   logic [7:0] display_ram [RAM_DEPTH];
   logic [7:0] rd_pipe;
   logic [8:0] f_out;
   logic f_valid, f_ready, f_in_ready;
   logic [7:0] next_dout;

   // two-stage synchronisers, first stage read by the second only
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         d_s1 <= 8'h00;
         d_s2 <= 8'h00;
         c_s1 <= 5'h00;
         c_s2 <= 5'h00;
         st_s1 <= 3'h0;
         st_s2 <= 3'h0;
      end else begin
         d_s1 <= bus.bus_d;
         d_s2 <= d_s1;
         c_s1 <= {bus.cs_high & ~bus.cs_low_n, bus.dc, bus.rw_wr,
            bus.e_rd, 1'b0};
         c_s2 <= c_s1;
         st_s1 <= {parallel_strap_i, bus_style_strap_i, 1'b0};
         st_s2 <= st_s1;
      end
   end
   // select is both chip selects together, seen through the sync pipe
   assign sel = c_s2[4];
   assign dc = c_s2[3];
   assign rw_wr = c_s2[2];
   assign e_rd = c_s2[1];
   assign sda = d_s2[`LHI_SDA_BIT];
   assign sck = d_s2[`LHI_SCK_BIT];

   // interface choice from the two straps, bus style ignored in serial
   // straps read serial for two cycles after reset, harmless while idle
   always_comb begin
      if (!st_s2[2]) begin
         mode = LHI_MSER;
      end else if (st_s2[1]) begin
         mode = LHI_M6800;
      end else begin
         mode = LHI_M8080;
      end
   end

   // active strobe: 6800 enable high, 8080 read low or write high
   always_comb begin
      if (mode == LHI_M6800) begin
         strobe = e_rd;
      end else if (mode == LHI_M8080) begin
         strobe = ~e_rd | rw_wr;
      end else begin
         strobe = 1'b0;
      end
   end
   // edges count only while selected; a deselected host can toggle
   // strobes and the serial clock freely without reaching the core
   assign strobe_rise = sel && strobe && !strobe_d;
   assign sck_rise = sel && sck && !sck_d && mode == LHI_MSER;

   // edge history; deselect clears it, so a strobe already high at select counts as an edge
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         strobe_d <= 1'b0;
         sck_d <= 1'b0;
      end else begin
         strobe_d <= strobe & sel;
         sck_d <= sck & sel;
      end
   end

   // access classification: parallel on the strobe's leading edge, serial on the eighth clock
   always_comb begin
      wr_ev = 1'b0;
      rd_ev = 1'b0;
      wr_byte = d_s2;
      wr_dc = dc;
      if (strobe_rise && mode == LHI_M6800) begin
         rd_ev = rw_wr;
         wr_ev = ~rw_wr;
      end else if (strobe_rise && mode == LHI_M8080) begin
         rd_ev = ~e_rd;
         wr_ev = e_rd & rw_wr;
      end else if (sck_rise && bitcnt == `LHI_SER_BITS - 4'h1) begin
         wr_ev = 1'b1;
         wr_byte = {shreg[6:0], sda};
      end
   end

   // serial shift register, msb first, cleared by reset
   // a mode change drops a partial byte rather than finish it later
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         shreg <= 8'h00;
         bitcnt <= 4'h0;
      end else if (mode != LHI_MSER) begin
         bitcnt <= 4'h0;
      end else if (sck_rise) begin
         shreg <= {shreg[6:0], sda};
         bitcnt <= (bitcnt == `LHI_SER_BITS - 4'h1) ? 4'h0
            : bitcnt + 4'h1;
      end
   end

   // display writes go to ram and bump the pointer; reads fetch ahead
   // the ram has no reset, so it keeps its bytes across a host reset;
   // a byte never written reads back unknown
   always_ff @(posedge ref_clk_i) begin
      if (wr_ev && wr_dc) begin
         display_ram[ram_addr_o] <= wr_byte;
      end
   end
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ram_addr_o <= '0;
         rd_pipe <= 8'h00;
      end else if (wr_ev && wr_dc) begin
         ram_addr_o <= ram_addr_o + `LHI_RAM_AW'(1);
      end else if (rd_ev && dc && mode != LHI_MSER) begin
         // the pipeline makes the host's first read a dummy
         rd_pipe <= display_ram[ram_addr_o];
         ram_addr_o <= ram_addr_o + `LHI_RAM_AW'(1);
      end
   end

   // read data: pipeline byte or status; serial never drives
   // status is caught at the strobe edge so the byte cannot tear
   always_comb begin
      next_dout = dc ? rd_pipe : status_i;
   end
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bus.dev_d_o <= 8'h00;
         bus.dev_d_oe <= 1'b0;
      end else if (!sel || mode == LHI_MSER) begin
         bus.dev_d_oe <= 1'b0;
      end else if (rd_ev) begin
         bus.dev_d_o <= next_dout;
         bus.dev_d_oe <= 1'b1;
      end else if (!strobe) begin
         bus.dev_d_oe <= 1'b0;
      end
   end

   // command bytes queue for the decoder; a full queue drops the byte
   // bit 8 of the queue word is spare and always zero
   lhi_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .in_data_i({1'b0, wr_byte}),
      .in_valid_i(wr_ev && !wr_dc),
      .in_ready_o(f_in_ready),
      .out_data_o(f_out),
      .out_valid_o(f_valid),
      .out_ready_i(f_ready)
   );
   assign f_ready = cmd_ready_i;
   assign cmd_valid_o = f_valid;
   assign cmd_o = f_out[7:0];
endmodule : lhi_device

// ==== src/lhi_defines.svh ====
// lhi_defines.svh: constants for the lcd host interface ends
// assumes: included by bare name from package and design files
`ifndef LHI_DEFINES_SVH
`define LHI_DEFINES_SVH
`define LHI_DATA_W 8
`define LHI_FIFO_DEPTH 8
`define LHI_SER_BITS 4'h8
`define LHI_SDA_BIT 7
`define LHI_SCK_BIT 6
`define LHI_RAM_DEPTH 1024
`define LHI_RAM_AW 10
`define LHI_STATUS_RST 8'h00
`define LHI_LINK_DIV 4'h3
`define LHI_HOLD_CYC 4'h4
`endif

// ==== src/lhi_pkg.sv ====
// lhi_pkg.sv: shared types of the lcd host interface
// assumes: lhi_defines.svh sits on the include path
package lhi_pkg;
`include "lhi_defines.svh"
   typedef enum logic [1:0] {LHI_M6800, LHI_M8080, LHI_MSER} lhi_mode_t;
   typedef enum logic [2:0] {LHI_H_IDLE, LHI_H_SETUP, LHI_H_STROBE,
      LHI_H_HOLD, LHI_H_SHIFT} lhi_hstate_t;
endpackage : lhi_pkg

// ==== src/lhi_if.sv ====
// lhi_if.sv: the pins between host and lcd controller
// assumes: data bus resolved here from the two enables
`timescale 1ns/100ps
interface lhi_if;
   logic cs_low_n; // chip_select_low_active, active low
   logic cs_high; // chip_select_high_active
   logic dc; // high data, low command
   logic rw_wr; // 6800 read/write, 8080 write strobe
   logic e_rd; // 6800 enable, 8080 read strobe
   logic [7:0] host_d_o; // host drive value
   logic host_d_oe; // host drives bus
   logic [7:0] dev_d_o; // device drive value
   logic dev_d_oe; // device drives bus
   logic [7:0] bus_d; // resolved bus level
   assign bus_d = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : 8'hFF);
   modport dev (input cs_low_n, cs_high, dc, rw_wr, e_rd, bus_d,
      output dev_d_o, dev_d_oe);
   modport host (output cs_low_n, cs_high, dc, rw_wr, e_rd, host_d_o,
      host_d_oe, input bus_d);
endinterface : lhi_if

// ==== src/lhi_fifo.sv ====
// lhi_fifo.sv: small synchronous fifo with valid/ready
// assumes: single clock, asynchronous active high reset
`timescale 1ns/100ps
module lhi_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk_i, // system clock
   input wire logic rst_i, // async reset
   input wire logic [WIDTH-1:0] in_data_i, // write word
   input wire logic in_valid_i, // write request
   output logic in_ready_o, // not full
   output logic [WIDTH-1:0] out_data_o, // head word
   output logic out_valid_o, // not empty
   input wire logic out_ready_i // read accept
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   logic [AW:0] count;
   logic push;
   logic pop;
   // honest full/empty from the occupancy count
   assign in_ready_o = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rptr];
   // storage has no reset, contents are qualified by count
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem[wptr] <= in_data_i;
      end
   end
   // pointers and count
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + AW'(1);
         end
         if (pop) begin
            rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + AW'(1);
         end
         if (push && !pop) begin
            count <= count + (AW+1)'(1);
         end else if (pop && !push) begin
            count <= count - (AW+1)'(1);
         end
      end
   end
endmodule : lhi_fifo

// ==== src/lhi_host.sv ====
// lhi_host.sv: microcontroller end driving the lcd host port
// assumes: straps are given to both ends alike; link clock derived here
`timescale 1ns/100ps
`include "lhi_defines.svh"
module lhi_host import lhi_pkg::*; (
   input wire logic ref_clk_i, // 20 mhz system clock
   input wire logic rst_i, // async reset, active high
   lhi_if.host bus, // device pins
   input wire logic parallel_strap_i, // high parallel
   input wire logic bus_style_strap_i, // high 6800
   input wire logic req_valid_i, // request present
   input wire logic req_read_i, // read, else write
   input wire logic req_dc_i, // data or command
   input wire logic [7:0] req_data_i, // write byte
   output logic req_ready_o, // request taken
   output logic [7:0] rd_data_o, // read byte
   output logic rd_valid_o // read byte pulse
);
   lhi_hstate_t state;
   lhi_mode_t mode;
   logic [3:0] tick;
   logic [3:0] nbit;
   logic rd;
   logic [7:0] sh;
   assign mode = !parallel_strap_i ? LHI_MSER
      : (bus_style_strap_i ? LHI_M6800 : LHI_M8080);
   assign req_ready_o = state == LHI_H_IDLE;

   // paced sequencer; setup, strobe and hold last LHI_HOLD_CYC+1 cycles, shift phases LHI_LINK_DIV+1
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= LHI_H_IDLE;
         tick <= 4'h0;
         nbit <= 4'h0;
         rd <= 1'b0;
         sh <= 8'h00;
         rd_data_o <= 8'h00;
         rd_valid_o <= 1'b0;
         bus.cs_low_n <= 1'b1;
         bus.cs_high <= 1'b0;
         bus.dc <= 1'b0;
         bus.rw_wr <= 1'b0;
         bus.e_rd <= 1'b1;
         bus.host_d_o <= 8'h00;
         bus.host_d_oe <= 1'b0;
      end else begin
         rd_valid_o <= 1'b0;
         tick <= tick + 4'h1;
         case (state)
            LHI_H_IDLE: begin
               tick <= 4'h0;
               bus.e_rd <= (mode != LHI_M6800);
               bus.rw_wr <= 1'b0;
               // serial cannot read; such a request is taken and dropped
               // without touching the pins
               if (req_valid_i && !(req_read_i && mode == LHI_MSER)) begin
                  rd <= req_read_i && mode != LHI_MSER;
                  sh <= req_data_i;
                  nbit <= 4'h0;
                  bus.cs_low_n <= 1'b0;
                  bus.cs_high <= 1'b1;
                  bus.dc <= req_dc_i;
                  bus.rw_wr <= req_read_i && mode == LHI_M6800;
                  bus.host_d_oe <= !(req_read_i && mode != LHI_MSER);
                  bus.host_d_o <= (mode == LHI_MSER) ?
                     {req_data_i[7], 1'b0, 6'h00} : req_data_i;
                  state <= (mode == LHI_MSER) ? LHI_H_SHIFT : LHI_H_SETUP;
               end
            end
            LHI_H_SETUP: if (tick == `LHI_HOLD_CYC) begin
               tick <= 4'h0;
               if (mode == LHI_M6800) begin
                  bus.e_rd <= 1'b1;
               end else if (rd) begin
                  bus.e_rd <= 1'b0;
               end else begin
                  bus.rw_wr <= 1'b1;
               end
               state <= LHI_H_STROBE;
            end
            LHI_H_STROBE: if (tick == `LHI_HOLD_CYC) begin
               tick <= 4'h0;
               rd_data_o <= bus.bus_d;
               rd_valid_o <= rd; // caller discards first
               bus.e_rd <= (mode != LHI_M6800);
               // 6800 direction holds until idle, past the device's drive
               bus.rw_wr <= rd && mode == LHI_M6800;
               state <= LHI_H_HOLD;
            end
            LHI_H_HOLD: if (tick == `LHI_HOLD_CYC) begin
               bus.cs_low_n <= 1'b1;
               bus.cs_high <= 1'b0;
               bus.host_d_oe <= 1'b0;
               state <= LHI_H_IDLE;
            end
            LHI_H_SHIFT: if (tick == `LHI_LINK_DIV) begin
               // clock high on odd phase, data changes while low
               tick <= 4'h0;
               if (!bus.host_d_o[6]) begin
                  bus.host_d_o[6] <= 1'b1;
                  nbit <= nbit + 4'h1;
               end else if (nbit == `LHI_SER_BITS) begin
                  bus.host_d_o[6] <= 1'b0;
                  state <= LHI_H_HOLD;
               end else begin
                  sh <= {sh[6:0], 1'b0};
                  bus.host_d_o <= {sh[6], 1'b0, 6'h00};
               end
            end
            default: state <= LHI_H_IDLE;
         endcase
      end
   end
endmodule : lhi_host

// ==== tb/lhi_props.sv ====
// lhi_props.sv: protocol checks on the pins between host and lcd end
// assumes: placed beside the interface; straps change only under reset
`timescale 1ns/100ps
module lhi_props (
   input wire logic ref_clk_i, // system clock
   input wire logic rst_i, // async reset, active high
   input wire logic parallel_strap_i, // high parallel
   input wire logic bus_style_strap_i, // high 6800
   input wire logic cs_low_n, // low selects
   input wire logic cs_high, // high selects
   input wire logic rw_wr, // 6800 direction, 8080 write
   input wire logic e_rd, // 6800 enable, 8080 read
   input wire logic host_d_oe, // host drives bus
   input wire logic dev_d_oe // device drives bus
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   // mode and select decodes
   wire logic sel = !cs_low_n && cs_high;
   wire logic m68 = parallel_strap_i && bus_style_strap_i;
   wire logic m80 = parallel_strap_i && !bus_style_strap_i;
   // eight quiet cycles outlast the sync pipe, so the bus must be free
   sequence s_en_quiet;
      (m68 && !e_rd) [*8];
   endsequence
   sequence s_rd_quiet;
      (m80 && e_rd) [*8];
   endsequence
   sequence s_rd_answer;
      ##[1:8] dev_d_oe;
   endsequence
   property p_one_driver;
      !(dev_d_oe && host_d_oe);
   endproperty
   a_one_driver: assert property (p_one_driver)
      else $error("both ends drive the bus");
   property p_sel_drive;
      dev_d_oe |-> sel;
   endproperty
   a_sel_drive: assert property (p_sel_drive)
      else $error("bus driven while deselected");
   property p_ser_wo;
      !parallel_strap_i |-> !dev_d_oe;
   endproperty
   a_ser_wo: assert property (p_ser_wo)
      else $error("serial end drives the bus");
   property p_dir;
      m68 && dev_d_oe |-> rw_wr;
   endproperty
   a_dir: assert property (p_dir)
      else $error("bus driven during a write cycle");
   property p_en_idle;
      s_en_quiet |-> !dev_d_oe;
   endproperty
   a_en_idle: assert property (p_en_idle)
      else $error("bus held without enable");
   property p_rd_idle;
      s_rd_quiet |-> !dev_d_oe;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("bus held without read strobe");
   property p_wr_sel;
      m80 && $rose(rw_wr) |-> sel;
   endproperty
   a_wr_sel: assert property (p_wr_sel)
      else $error("write strobe while deselected");
   property p_rd_sel;
      m80 && $fell(e_rd) |-> sel;
   endproperty
   a_rd_sel: assert property (p_rd_sel)
      else $error("read strobe while deselected");
   property p_rd_answer;
      m80 && $fell(e_rd) |-> s_rd_answer;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read strobe not answered");
endmodule : lhi_props

// ==== tb/lcd_host_interface_bench.sv ====
// lcd_host_interface_bench.sv: host and lcd end joined, all three modes
// assumes: src/ files compiled first; expectations queued by the driver
`timescale 1ns/100ps
module lcd_host_interface_bench;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic parallel_strap_i = 1'b1;
   logic bus_style_strap_i = 1'b1;
   logic [7:0] status_i = 8'h00;
   logic cmd_ready_i = 1'b1;
   logic req_valid_i = 1'b0;
   logic req_read_i = 1'b0;
   logic req_dc_i = 1'b0;
   logic [7:0] req_data_i = 8'h00;
   logic [7:0] cmd_o, rd_data_o, sh;
   logic cmd_valid_o, req_ready_o, rd_valid_o, sck_d;
   logic [9:0] ram_addr_o, n_addr;
   logic [8:0] rd_q[$];
   logic [7:0] cmd_q[$], wire_q[$], ram_q[$];
   logic [31:0] seed = 32'h0000_004A;
   int nbit = 0;
   int n_fail = 0;
   int n_compared = 0;
   lhi_if u_lhi_if();
   lhi_device u_lhi_device (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .bus(u_lhi_if.dev), .parallel_strap_i(parallel_strap_i),
      .bus_style_strap_i(bus_style_strap_i), .status_i(status_i),
      .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i),
      .ram_addr_o(ram_addr_o));
   lhi_host u_lhi_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .bus(u_lhi_if.host), .parallel_strap_i(parallel_strap_i),
      .bus_style_strap_i(bus_style_strap_i), .req_valid_i(req_valid_i),
      .req_read_i(req_read_i), .req_dc_i(req_dc_i), .req_data_i(req_data_i),
      .req_ready_o(req_ready_o), .rd_data_o(rd_data_o),
      .rd_valid_o(rd_valid_o));
   lhi_props u_lhi_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .parallel_strap_i(parallel_strap_i),
      .bus_style_strap_i(bus_style_strap_i),
      .cs_low_n(u_lhi_if.cs_low_n), .cs_high(u_lhi_if.cs_high),
      .rw_wr(u_lhi_if.rw_wr), .e_rd(u_lhi_if.e_rd),
      .host_d_oe(u_lhi_if.host_d_oe), .dev_d_oe(u_lhi_if.dev_d_oe));
   // 20 mhz system clock
   initial begin
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   // xorshift source, fixed start so runs repeat
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd
   task automatic miss(input string m);
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
   endtask : miss
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) miss("byte differs");
   endtask : chk_byte
   task automatic chk_addr(input logic [9:0] got, input logic [9:0] exp);
      n_compared++;
      if (got !== exp) miss("count differs");
   endtask : chk_addr
   // one request, held until the host takes it
   task automatic req(input logic rd, input logic dc, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      req_valid_i <= 1'b1;
      req_read_i <= rd;
      req_dc_i <= dc;
      req_data_i <= d;
      do @(negedge ref_clk_i); while (req_ready_o !== 1'b1 && n++ < 4000);
      if (req_ready_o !== 1'b1) miss("request not taken");
      @(posedge ref_clk_i);
      req_valid_i <= 1'b0;
   endtask : req
   // write; a command byte is expected only if the fifo has room
   task automatic wr(input logic dc, input logic keep);
      logic [7:0] d;
      d = rnd();
      if (dc) n_addr++;
      else if (keep) cmd_q.push_back(d);
      if (dc) ram_q.push_back(d);
      if (!parallel_strap_i) wire_q.push_back(d);
      req(1'b0, dc, d);
   endtask : wr
   // read; bit 8 of e marks a byte to check, serial reads are dropped
   task automatic rd(input logic dc, input logic [8:0] e);
      if (parallel_strap_i && dc) n_addr++;
      if (parallel_strap_i) rd_q.push_back(e);
      req(1'b1, dc, 8'h00);
   endtask : rd
   task automatic idle();
      int n;
      n = 0;
      do @(negedge ref_clk_i); while (req_ready_o !== 1'b1 && n++ < 4000);
      if (req_ready_o !== 1'b1) miss("host never idle");
      repeat (12) @(negedge ref_clk_i);
   endtask : idle
   // results judged at the falling edge, where outputs have settled
   always @(negedge ref_clk_i) begin
      logic [8:0] e;
      if (rst_i !== 1'b0) nbit = 0;
      else begin
         if (cmd_valid_o === 1'b1 && cmd_ready_i === 1'b1) begin
            if (cmd_q.size() == 0) miss("extra command");
            else chk_byte(cmd_o, cmd_q.pop_front());
         end
         if (rd_valid_o === 1'b1) begin
            if (rd_q.size() == 0) miss("extra read");
            else begin
               e = rd_q.pop_front();
               if (e[8]) chk_byte(rd_data_o, e[7:0]);
            end
         end
         // wire watch: msb first on rising sck while selected
         if (!parallel_strap_i && u_lhi_if.cs_low_n === 1'b0 &&
               sck_d === 1'b0 && u_lhi_if.bus_d[6] === 1'b1) begin
            sh = {sh[6:0], u_lhi_if.bus_d[7]};
            nbit++;
            if (nbit == 8) begin
               nbit = 0;
               if (wire_q.size() == 0) miss("extra serial byte");
               else chk_byte(sh, wire_q.pop_front());
            end
         end
      end
      sck_d = u_lhi_if.bus_d[6];
   end
   // 6800, 8080, then serial, each from a fresh reset
   initial begin
      for (int m = 0; m < 3; m++) begin
         @(posedge ref_clk_i);
         rst_i <= 1'b1;
         parallel_strap_i <= (m != 2);
         bus_style_strap_i <= (m == 0);
         status_i <= rnd();
         ram_q.delete();
         repeat (2) @(posedge ref_clk_i);
         rst_i <= 1'b0;
         n_addr = 10'h000;
         // fifo held full: the ninth command is dropped
         cmd_ready_i <= 1'b0;
         for (int i = 0; i < 9; i++) wr(1'b0, i < 8);
         idle();
         @(posedge ref_clk_i);
         cmd_ready_i <= 1'b1;
         for (int i = 0; i < 3; i++) wr(1'b1, 1'b1);
         rd(1'b0, {1'b1, status_i});
         idle();
         chk_addr(ram_addr_o, n_addr);
         // mid-run reset: the pointer restarts, the ram keeps its bytes
         @(posedge ref_clk_i);
         rst_i <= 1'b1;
         repeat (2) @(posedge ref_clk_i);
         rst_i <= 1'b0;
         n_addr = 10'h000;
         rd(1'b1, 9'h000);
         rd(1'b1, {1'b1, ram_q[0]});
         rd(1'b1, {1'b1, ram_q[1]});
         idle();
         chk_addr(ram_addr_o, n_addr);
         chk_addr(10'(cmd_q.size() + rd_q.size() + wire_q.size()),
            10'h000);
         $display("test mode %0d done", m);
      end
      print_verdict();
   end
   // watchdog: a hung handshake ends the run as a failure
   initial begin
      repeat (50000) @(posedge ref_clk_i);
      miss("watchdog expired");
      print_verdict();
   end
   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
endmodule : lcd_host_interface_bench
